// [core/bsse_alu.sv]
// decoder and datapath for skip-if-clear, subtract and nibble exchange
// assumes operands already fetched from the file registers; purely combinational
`default_nettype none

module bsse_alu (
    // instruction and operands
    input wire logic [11:0] instr,
    input wire logic [7:0] file_val,
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic fuse_bit,
    // decode results
    output bsse_pkg::bsse_op_e op,
    output logic [4:0] file_addr,
    output logic bit_clear,
    // arithmetic results
    output logic [7:0] result,
    output logic carry_out,
    output logic half_borrow_out,
    output logic zero_out
);

    logic borrow_in;   // inverted carry when fuse programmed low
    logic [8:0] diff;  // nine bits keep the borrow out of bit 7
    logic [4:0] low_diff;  // low nibble difference with borrow
    logic [2:0] bit_idx;

    // opcode match, skip pattern checked first as it is widest
    always_comb begin
        if ((instr & bsse_pkg::SKIP_MASK) == bsse_pkg::SKIP_CODE) begin
            op = bsse_pkg::BSSE_OP_SKIP;
        end else if ((instr & bsse_pkg::SUB_MASK) == bsse_pkg::SUB_CODE) begin
            op = bsse_pkg::BSSE_OP_SUB;
        end else if ((instr & bsse_pkg::SWAP_MASK)
                     == bsse_pkg::SWAP_CODE) begin
            op = bsse_pkg::BSSE_OP_SWAP;
        end else begin
            op = bsse_pkg::BSSE_OP_NONE;
        end
    end

    // operand fields
    assign file_addr = instr[bsse_pkg::ADDR_W-1:0];
    assign bit_idx = instr[bsse_pkg::BIT_LSB +: bsse_pkg::BIT_W];
    assign bit_clear = ~file_val[bit_idx];

    // borrow-in only when the fuse bit reads 0
    assign borrow_in = fuse_bit ? 1'b0 : ~carry_in;
    assign diff = {1'b0, file_val} - {1'b0, acc} - {8'h00, borrow_in};
    assign low_diff = {1'b0, file_val[3:0]} - {1'b0, acc[3:0]}
                      - {4'h0, borrow_in};

    // result and flags
    always_comb begin
        if (op == bsse_pkg::BSSE_OP_SWAP) begin
            result = {file_val[3:0], file_val[7:4]};
        end else begin
            result = diff[7:0];
        end
    end
    assign carry_out = ~diff[8];
    assign half_borrow_out = ~low_diff[4];
    assign zero_out = (diff[7:0] == 8'h00);

endmodule : bsse_alu

`default_nettype wire

// [core/bsse_exec.sv]
// execution unit for skip-if-clear, subtract and nibble exchange
// assumes fetch presents one instruction word with a valid strobe and an
// apb master on the same clock; file registers, accumulator, flags and
// the extended config word live here and are reachable over apb
`default_nettype none

// Behaviour
// - decode 0110 bbb fffff as bit-test skip
// - skip next instruction when tested bit clear
// - skip test: one cycle, two when skipping
// - subtract accumulator from file register, write back
// - carry cleared on borrow, else set
// - half borrow flag cleared on nibble borrow
// - zero flag set when result is 00h
// - fuse bit 0: also subtract inverted carry
// - fuse bit 1: plain subtract, carry ignored
// - 0011 101 fffff swaps file register nibbles
module bsse_exec (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction from fetch
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    output logic instr_ready,
    // retire report to fetch
    output logic done,
    output logic skip_next,
    output logic not_ours,
    // flags for the rest of the core
    output logic carry_flag,
    output logic half_borrow_flag,
    output logic zero_flag
);

    // execution states
    typedef enum logic [1:0] {
        BSSE_ST_RUN = 2'b01,   // ready for a new word
        BSSE_ST_SKIP = 2'b10   // second cycle of a taken skip
    } bsse_state_e;

    bsse_state_e state_r;
    bsse_state_e state_nxt;

    // architectural state
    logic [7:0] file_r [bsse_pkg::NUM_FILE];  // file register set
    logic [7:0] acc_r;                         // accumulator
    logic carry_r;
    logic half_borrow_r;
    logic zero_r;
    logic fuse_r;                               // borrow_in_fuse_bit
    logic [bsse_pkg::RETIRE_W-1:0] retire_r;   // retired instruction count
    logic last_skip_r;
    logic last_ill_r;

    // handshake and report flops
    logic ready_r;
    logic done_r;
    logic skip_r;
    logic ill_r;

    // apb flops
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // datapath wires
    bsse_pkg::bsse_op_e op;
    logic [4:0] exe_addr;
    logic bit_clear;
    logic [7:0] alu_result;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic accept;     // word taken this edge
    logic exe_we;     // file write from execution
    logic bus_setup;  // apb setup phase
    logic bus_we;     // apb write commits this edge
    logic file_hit;   // apb address falls in the file window
    logic [4:0] file_idx;

    // address decode for the setup-phase error answer, which in turn gates the write commit
    function automatic logic addr_mapped(input logic [11:0] a);
        logic in_file;
        in_file = (a >= bsse_pkg::REG_FILE_BASE) && (a[1:0] == 2'b00)
                  && (a < bsse_pkg::REG_FILE_BASE + 12'h080);
        addr_mapped = in_file || a == bsse_pkg::REG_EXT_CFG
                      || a == bsse_pkg::REG_FLAGS
                      || a == bsse_pkg::REG_ACC
                      || a == bsse_pkg::REG_RETIRE
                      || a == bsse_pkg::REG_LAST;
    endfunction : addr_mapped

    assign file_hit = (paddr >= bsse_pkg::REG_FILE_BASE)
                      && (paddr < bsse_pkg::REG_FILE_BASE + 12'h080)
                      && (paddr[1:0] == 2'b00);
    assign file_idx = paddr[6:2];
    assign bus_setup = psel && !penable;
    // write lands only on the access edge, never for an unmapped address
    assign bus_we = psel && penable && pready_r && pwrite && !pslverr_r;

    // datapath reads the addressed file register combinationally
    bsse_alu u_alu (
        .instr(instr_word),
        .file_val(file_r[instr_word[4:0]]),
        .acc(acc_r),
        .carry_in(carry_r),
        .fuse_bit(fuse_r),
        .op(op),
        .file_addr(exe_addr),
        .bit_clear(bit_clear),
        .result(alu_result),
        .carry_out(alu_c),
        .half_borrow_out(alu_dc),
        .zero_out(alu_z)
    );

    // a word is taken only while ready, which drops during a skip
    assign accept = instr_valid && ready_r;
    assign exe_we = accept && (op == bsse_pkg::BSSE_OP_SUB
                               || op == bsse_pkg::BSSE_OP_SWAP);

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BSSE_ST_RUN: begin
                if (accept && op == bsse_pkg::BSSE_OP_SKIP && bit_clear) begin
                    state_nxt = BSSE_ST_SKIP;
                end
            end
            BSSE_ST_SKIP: begin
                state_nxt = BSSE_ST_RUN;
            end
            default: begin
                state_nxt = BSSE_ST_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= BSSE_ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ready falls for the extra cycle of a taken skip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= 1'b1;
        end else begin
            ready_r <= (state_nxt == BSSE_ST_RUN);
        end
    end

    // retire report: pulse one cycle after accept, or two for a taken skip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
            ill_r <= 1'b0;
        end else if (state_r == BSSE_ST_SKIP) begin
            done_r <= 1'b1;
            skip_r <= 1'b1;
            ill_r <= 1'b0;
        end else if (accept && !(op == bsse_pkg::BSSE_OP_SKIP
                                 && bit_clear)) begin
            done_r <= 1'b1;
            skip_r <= 1'b0;
            ill_r <= (op == bsse_pkg::BSSE_OP_NONE);
        end else begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
            ill_r <= 1'b0;
        end
    end

    // retired count and last outcome, for software to watch progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retire_r <= '0;
            last_skip_r <= 1'b0;
            last_ill_r <= 1'b0;
        end else if (done_r) begin
            retire_r <= retire_r + 16'h0001;
            last_skip_r <= skip_r;
            last_ill_r <= ill_r;
        end
    end

    // file registers; execution beats a same-cycle bus write to one entry
    generate
        for (genvar i = 0; i < bsse_pkg::NUM_FILE; i++) begin : g_file
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    file_r[i] <= bsse_pkg::FILE_RST;
                end else if (exe_we && exe_addr == 5'(i)) begin
                    file_r[i] <= alu_result;
                end else if (bus_we && file_hit && file_idx == 5'(i)) begin
                    file_r[i] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // status flags; only subtract touches them, and it wins over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_r <= bsse_pkg::FLAGS_RST[bsse_pkg::FLAG_C];
            half_borrow_r <= bsse_pkg::FLAGS_RST[bsse_pkg::FLAG_DC];
            zero_r <= bsse_pkg::FLAGS_RST[bsse_pkg::FLAG_Z];
        end else if (accept && op == bsse_pkg::BSSE_OP_SUB) begin
            carry_r <= alu_c;
            half_borrow_r <= alu_dc;
            zero_r <= alu_z;
        end else if (bus_we && paddr == bsse_pkg::REG_FLAGS) begin
            // software write of the flags register; skip test and swap never write the flags
            carry_r <= pwdata[bsse_pkg::FLAG_C];
            half_borrow_r <= pwdata[bsse_pkg::FLAG_DC];
            zero_r <= pwdata[bsse_pkg::FLAG_Z];
        end
    end

    // accumulator; subtract never writes it, only software does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= bsse_pkg::ACC_RST;
        end else if (bus_we && paddr == bsse_pkg::REG_ACC) begin
            acc_r <= pwdata[7:0];
        end
    end

    // extended config word; the fuse bit picks borrow-in behaviour
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_r <= bsse_pkg::FUSE_RST;
        end else if (bus_we && paddr == bsse_pkg::REG_EXT_CFG) begin
            fuse_r <= pwdata[bsse_pkg::FUSE_BIT];
        end
    end

    // apb answer: ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (bus_setup) begin
            pready_r <= 1'b1;
            pslverr_r <= !addr_mapped(paddr);
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // read data sampled at setup; an execution write on that same edge
    // is not seen, a limitation traded for a zero-wait answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (bus_setup && !pwrite) begin
            prdata_r <= 32'h0000_0000;
            if (file_hit) begin
                prdata_r[7:0] <= file_r[file_idx];
            end else if (paddr == bsse_pkg::REG_EXT_CFG) begin
                prdata_r[bsse_pkg::FUSE_BIT] <= fuse_r;
            end else if (paddr == bsse_pkg::REG_FLAGS) begin
                prdata_r[bsse_pkg::FLAG_C] <= carry_r;
                prdata_r[bsse_pkg::FLAG_DC] <= half_borrow_r;
                prdata_r[bsse_pkg::FLAG_Z] <= zero_r;
            end else if (paddr == bsse_pkg::REG_ACC) begin
                prdata_r[7:0] <= acc_r;
            end else if (paddr == bsse_pkg::REG_RETIRE) begin
                prdata_r[bsse_pkg::RETIRE_W-1:0] <= retire_r;
            end else if (paddr == bsse_pkg::REG_LAST) begin
                prdata_r[bsse_pkg::LAST_SKIP] <= last_skip_r;
                prdata_r[bsse_pkg::LAST_ILL] <= last_ill_r;
            end
        end
    end

    // outputs straight from flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign instr_ready = ready_r;
    assign done = done_r;
    assign skip_next = skip_r;
    assign not_ours = ill_r;
    assign carry_flag = carry_r;
    assign half_borrow_flag = half_borrow_r;
    assign zero_flag = zero_r;

endmodule : bsse_exec

`default_nettype wire

// [core/bsse_pkg.sv]
// constants shared by the bit-test, subtract and nibble-exchange core
// assumes a 12-bit instruction word and a 32-entry, 8-bit file register set
`default_nettype none

package bsse_pkg;

    // instruction word layout
    localparam int INSTR_W = 12;     // instruction width
    localparam int DATA_W = 8;       // file register width
    localparam int ADDR_W = 5;       // file register address width
    localparam int NUM_FILE = 32;    // file registers 00h..1fh
    localparam int BIT_LSB = 5;      // bit index field lsb
    localparam int BIT_W = 3;        // bit index field width
    localparam int NIB_W = 4;        // nibble width

    // opcode masks and match values
    localparam logic [11:0] SKIP_MASK = 12'hf00;
    localparam logic [11:0] SKIP_CODE = 12'h600;  // 0110 bbbf ffff
    localparam logic [11:0] SUB_MASK = 12'hfe0;
    localparam logic [11:0] SUB_CODE = 12'h0a0;   // 0000 101f ffff
    localparam logic [11:0] SWAP_MASK = 12'hfe0;
    localparam logic [11:0] SWAP_CODE = 12'h3a0;  // 0011 101f ffff

    // decoded operation kinds, one-hot
    typedef enum logic [3:0] {
        BSSE_OP_NONE = 4'h1,
        BSSE_OP_SKIP = 4'h2,
        BSSE_OP_SUB = 4'h4,
        BSSE_OP_SWAP = 4'h8
    } bsse_op_e;

    // apb byte offsets
    localparam logic [11:0] REG_EXT_CFG = 12'h000;  // extended_config_word
    localparam logic [11:0] REG_FLAGS = 12'h004;    // status flags
    localparam logic [11:0] REG_ACC = 12'h008;      // accumulator
    localparam logic [11:0] REG_RETIRE = 12'h00c;   // retired count, ro
    localparam logic [11:0] REG_LAST = 12'h010;     // last outcome, ro
    localparam logic [11:0] REG_FILE_BASE = 12'h080; // file regs, 4 apart

    // field positions
    localparam int FUSE_BIT = 0;    // borrow_in_fuse_bit in ext cfg
    localparam int FLAG_C = 0;      // carry flag
    localparam int FLAG_DC = 1;     // half_borrow_flag
    localparam int FLAG_Z = 2;      // zero flag
    localparam int LAST_SKIP = 0;   // last retired op skipped
    localparam int LAST_ILL = 1;    // last retired op not ours

    // reset values
    localparam logic FUSE_RST = 1'b1;          // default: no borrow-in
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam int RETIRE_W = 16;              // retired counter width

endpackage : bsse_pkg

`default_nettype wire

// [dv/bsse_exec_chk.sv]
// handshake and timing checks on the execution unit's ports
// assumes one clock domain, bound to every bsse_exec instance
`default_nettype none

module bsse_exec_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // instruction handshake
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic instr_ready,
    input wire logic done,
    input wire logic skip_next,
    input wire logic not_ours,
    // status flags
    input wire logic carry_flag,
    input wire logic half_borrow_flag,
    input wire logic zero_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // decoded view of the word taken at this edge
    logic take;
    logic is_skip;
    logic is_sub;
    logic is_swap;
    logic [2:0] flags;
    assign take = instr_valid && instr_ready;
    assign is_skip = (instr_word & bsse_pkg::SKIP_MASK) == bsse_pkg::SKIP_CODE;
    assign is_sub = (instr_word & bsse_pkg::SUB_MASK) == bsse_pkg::SUB_CODE;
    assign is_swap = (instr_word & bsse_pkg::SWAP_MASK) == bsse_pkg::SWAP_CODE;
    assign flags = {zero_flag, half_borrow_flag, carry_flag};

    a_skip_timing: assert property (take && is_skip |=> (done && !skip_next)
        or (!instr_ready && !done ##1 done && skip_next))
        else $error("skip retired with wrong timing");
    a_skip_flags: assert property (take && is_skip |=> $stable(flags))
        else $error("skip changed a flag");
    a_gap_end: assert property (!instr_ready |=> instr_ready && done
        && skip_next) else $error("skip gap not exactly one cycle");
    a_skip_cause: assert property ($fell(instr_ready) |->
        $past(take && is_skip)) else $error("ready dropped without skip");
    a_sub_single: assert property (take && is_sub |=> done && instr_ready
        && !skip_next && !not_ours) else $error("subtract not one cycle");
    a_swap_flags: assert property (take && is_swap |=> done && !not_ours
        && $stable(flags)) else $error("swap retired badly");
    a_foreign_op: assert property (take && !(is_skip || is_sub || is_swap)
        |=> done && not_ours && !skip_next) else $error("foreign word misread");
    a_done_cause: assert property (done |-> $past(take)
        || !$past(instr_ready)) else $error("done without a taken word");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("apb access not answered in one cycle");
endmodule : bsse_exec_chk

bind bsse_exec bsse_exec_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .done(done), .skip_next(skip_next),
    .not_ours(not_ours), .carry_flag(carry_flag),
    .half_borrow_flag(half_borrow_flag), .zero_flag(zero_flag));

`default_nettype wire

// [dv/bsse_fetch_model.sv]
// fetch-side model: offers instruction words to the execution unit
// assumes the bench calls run() after reset, on the same clock
`default_nettype none

module bsse_fetch_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // handshake with the execution unit
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [11:0] instr_word
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle at time zero
    initial begin
        instr_valid = 1'b0;
        instr_word = 12'h000;
    end

    // offer each word after gap idle cycles and hold it until taken;
    // ready is sampled at the edge, before that edge's own update lands
    task automatic run(input logic [11:0] q[$], input int gap);
        logic rdy;
        @(posedge pclk);
        foreach (q[i]) begin
            if (gap > 0) begin
                instr_valid <= 1'b0;
                instr_word <= ~instr_word;  // no stale word while idle
                repeat (gap) @(posedge pclk);
            end
            instr_valid <= 1'b1;
            instr_word <= q[i];
            do begin
                @(posedge pclk);
                rdy = instr_ready;
            end while (!rdy);
        end
        instr_valid <= 1'b0;
        instr_word <= ~q[q.size()-1];
    endtask : run
endmodule : bsse_fetch_model

`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the skip, subtract and nibble-exchange unit
// assumes the fetch model and checker are compiled before this file
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // bench-driven inputs, plus the prdata read bus
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    // design and fetch-model outputs
    logic pready, pslverr, instr_valid, instr_ready, done, skip_next;
    logic not_ours, carry_flag, half_borrow_flag, zero_flag;
    logic [11:0] instr_word;
    int error_cnt = 0;
    int samples_checked = 0;

    // 100 ns clock
    always #50 pclk = ~pclk;

    bsse_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .done(done), .skip_next(skip_next),
        .not_ours(not_ours), .carry_flag(carry_flag),
        .half_borrow_flag(half_borrow_flag), .zero_flag(zero_flag));
    bsse_fetch_model u_fetch (.pclk(pclk), .presetn(presetn),
        .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_word(instr_word));

    // one apb transfer; pready, prdata and pslverr are taken at the edge
    // that samples pready high, before that edge's own update lands
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        logic r;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            r = pready;
            q = prdata;
            e = pslverr;
        end while (!r);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, x)
    endtask : rdc

    function automatic logic [11:0] fa(input logic [4:0] n);
        return bsse_pkg::REG_FILE_BASE + {5'h0, n, 2'b00};
    endfunction : fa

    // issue one word, count cycles to its retire pulse (bounded)
    task automatic ex(input logic [11:0] w, input int gap, output int cyc,
            output logic sk);
        logic [11:0] q[$];
        q.push_back(w);
        u_fetch.run(q, gap);
        cyc = 0;
        do begin
            @(negedge pclk);
            cyc++;
        end while (!done && cyc < 8);
        sk = skip_next;
    endtask : ex

    // reset values, read-only and unmapped places
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        @(negedge pclk);
        `CHK(instr_ready, 1'b1)
        `CHK({zero_flag, half_borrow_flag, carry_flag}, bsse_pkg::FLAGS_RST)
        rdc(bsse_pkg::REG_EXT_CFG, 32'h1);
        rdc(bsse_pkg::REG_ACC, 32'h0);
        wr(bsse_pkg::REG_RETIRE, 32'hffff);
        rdc(bsse_pkg::REG_RETIRE, 32'h0);
        apb(1'b0, 12'h014, 32'h0, q, e);
        `CHK(e, 1'b1)
    endtask : t_reset

    // fuse, carry-in, file value, accumulator; flags from a bench model
    task automatic t_sub();
        logic [17:0] tv[8] = '{18'h33506, 18'h20606, 18'h30506, 18'h31001,
            18'h03506, 18'h10606, 18'h00000, 18'h0f1f0};
        logic [8:0] r;
        logic [4:0] lo;
        logic bin, sk;
        int cyc;
        foreach (tv[i]) begin
            bin = !tv[i][17] && !tv[i][16];  // borrow only with fuse at 0
            r = {1'b0, tv[i][15:8]} - {1'b0, tv[i][7:0]} - 9'(bin);
            lo = {1'b0, tv[i][11:8]} - {1'b0, tv[i][3:0]} - 5'(bin);
            wr(bsse_pkg::REG_EXT_CFG, {31'h0, tv[i][17]});
            wr(bsse_pkg::REG_FLAGS, {31'h0, tv[i][16]});
            wr(fa(5'(i + 3)), {24'h0, tv[i][15:8]});
            wr(bsse_pkg::REG_ACC, {24'h0, tv[i][7:0]});
            ex({7'h05, 5'(i + 3)}, 0, cyc, sk);
            `CHK(cyc, 1)
            `CHK(carry_flag, !r[8])
            `CHK(half_borrow_flag, !lo[4])
            `CHK(zero_flag, r[7:0] == 8'h00)
            rdc(fa(5'(i + 3)), {24'h0, r[7:0]});
            rdc(bsse_pkg::REG_ACC, {24'h0, tv[i][7:0]});
        end
    endtask : t_sub

    // swap then subtract back to back, then a slow lone swap
    task automatic t_swap();
        logic [11:0] q[$];
        logic sk;
        int cyc;
        wr(bsse_pkg::REG_EXT_CFG, 32'h1);
        wr(fa(5'h1f), 32'ha5);
        wr(fa(5'h0b), 32'ha5);
        wr(bsse_pkg::REG_ACC, 32'h0a);
        q = '{12'h3bf, 12'h0bf};
        u_fetch.run(q, 0);
        repeat (2) @(negedge pclk);
        rdc(fa(5'h1f), 32'h50);
        ex(12'h3ab, 2, cyc, sk);
        `CHK(cyc, 1)
        `CHK({zero_flag, half_borrow_flag, carry_flag}, 3'h3)
        rdc(fa(5'h0b), 32'h5a);
    endtask : t_swap

    // every bit index, clear and set, over spread addresses
    task automatic t_skip();
        logic [11:0] q[$];
        logic [7:0] m;
        logic sk;
        int cyc;
        wr(bsse_pkg::REG_FLAGS, 32'h5);
        for (int b = 0; b < 8; b++) begin
            for (int v = 0; v < 2; v++) begin
                m = 8'h01 << b;
                wr(fa(5'(b * 4 + 3)), {24'h0, v != 0 ? m : ~m});
                ex({4'h6, 3'(b), 5'(b * 4 + 3)}, 0, cyc, sk);
                `CHK(cyc, v != 0 ? 1 : 2)
                `CHK(sk, v == 0)
            end
        end
        // taken skip on 1fh bit 0, then a swap held through the gap;
        // a swap taken twice would bring 80h back
        q = '{12'h61f, 12'h3bf};
        u_fetch.run(q, 0);
        repeat (2) @(negedge pclk);
        rdc(fa(5'h1f), 32'h08);
        `CHK({zero_flag, half_borrow_flag, carry_flag}, 3'h5)
    endtask : t_skip

    // a word of another instruction retires with no effect
    task automatic t_foreign();
        logic sk;
        int cyc;
        // a set-bit word on 1fh bit 7 would make this d0h
        wr(fa(5'h1f), 32'h50);
        ex(12'h5ff, 0, cyc, sk);
        `CHK(cyc, 1)
        `CHK(not_ours, 1'b1)
        rdc(fa(5'h1f), 32'h50);
        rdc(bsse_pkg::REG_LAST, 32'h2);
        // 8 subtracts, 3 in the swap test, 18 skip test words, 1 here
        rdc(bsse_pkg::REG_RETIRE, 32'h1e);
    endtask : t_foreign

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sub();
        t_swap();
        t_skip();
        t_foreign();
        conclude();
    end

    // watchdog, far beyond the few hundred cycles expected
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end
endmodule : testbench

`default_nettype wire
